// ---- src/lss_pkg.sv ----
// Shared constants and types for the laser startup state sequencer.
package lss_pkg;

  // ==========================================================================
  // Register map, byte addresses on the APB bus.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PWR_SET = 8'h0C;
  localparam logic [7:0] ADDR_CUR_SET = 8'h10;
  localparam logic [7:0] ADDR_WARM_CUR = 8'h14;
  localparam logic [7:0] ADDR_WARM_TIME = 8'h18;

  // ==========================================================================
  // Command register bits, each a one-cycle strobe when written as one.
  localparam int CMD_STOP = 0;
  localparam int CMD_START = 1;
  localparam int CMD_RESTART = 2;
  localparam int CMD_ABORT = 3;
  localparam int CMD_CLR_FAULT = 4;

  // ==========================================================================
  // Configuration register fields and reset values.
  localparam int CFG_AUTO = 0;
  localparam int CFG_REMOTE = 1;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_MODE_MSB = 7;
  localparam logic CFG_AUTO_RST = 1'b1;
  localparam logic CFG_REMOTE_RST = 1'b0;

  // ==========================================================================
  // Run modes, one-hot.
  localparam logic [3:0] MODE_CONST_PWR = 4'h1;
  localparam logic [3:0] MODE_CONST_CUR = 4'h2;
  localparam logic [3:0] MODE_PWR_MOD = 4'h4;
  localparam logic [3:0] MODE_CUR_MOD = 4'h8;

  // ==========================================================================
  // Status register fields.
  localparam int STS_STATE_LSB = 0;
  localparam int STS_STATE_MSB = 2;
  localparam int STS_ILOCK = 4;
  localparam int STS_KEY = 5;
  localparam int STS_REMOTE = 6;
  localparam int STS_TEMP_OK = 7;

  // ==========================================================================
  // Widths and timing.
  localparam int VAL_W = 16;
  localparam int SECS_W = 16;
  localparam logic [VAL_W-1:0] VAL_ZERO = 16'h0000;
  localparam logic [SECS_W-1:0] SECS_ZERO = 16'h0000;
  localparam longint CLK_HZ = 40000000;
  localparam longint ILOCK_FILT_US = 10000;
  localparam longint ILOCK_FILT_CYC = (ILOCK_FILT_US * CLK_HZ) / 1000000;

  // ==========================================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_WAIT_KEY = 3'b001,
    ST_WAIT_REMOTE = 3'b010,
    ST_WAIT_TEMP = 3'b011,
    ST_WARMUP = 3'b100,
    ST_LASER_ON = 3'b101,
    ST_FAULT = 3'b110,
    ST_ABORTED = 3'b111
  } lss_state_t;

endpackage : lss_pkg

// ---- src/lss_filter.sv ----
// Two-flop synchroniser followed by a stability filter for one pin.
`timescale 1ns/100ps
module lss_filter #(
  parameter int unsigned FILT_CYC = 4,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  import lss_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1) + 1;

  logic sync1;
  logic sync2;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_level;

  // ==========================================================================
  // Synchroniser; the first flop feeds only the second.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= RST_VAL;
      sync2 <= RST_VAL;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // Accept a new level only once it has held for the full filter time.
  // Glitches shorter than that are swallowed, at the cost of latency.
  always_comb begin
    next_cnt = cnt;
    next_level = level;
    if (sync2 == level) begin
      next_cnt = '0;
    end else if (cnt >= CW'(FILT_CYC - 1)) begin
      next_cnt = '0;
      next_level = sync2;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      level <= RST_VAL;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
    end
  end

endmodule : lss_filter

// ---- src/lss_seq.sv ----
// Laser startup and operating-state sequencer with an APB register file.
// Function
// (RULE1) Abort command or cleared fault enters Aborted.
// (RULE2) Aborted: emission inhibited, temperature drives off.
// (RULE3) Fault-caused abort passes through Fault first.
// (RULE4) Only restart command leaves Aborted; a detected fault also moves it to Fault.
// (RULE5) After reset, first state is Standby.
// (RULE6) Stop command enters Standby, emission off.
// (RULE7) Standby keeps enabled temperature controllers running.
// (RULE8) Start or restart from Standby reruns sequence.
// (RULE9) Key wait needs key OFF then ON.
// (RULE10) Operator may need two key toggles.
// (RULE11) Remote enabled: wait for remote ON after key.
// (RULE12) Autostart holds until all temperatures settled.
// (RULE13) Settled temperatures advance through warm-up to on.
// (RULE14) Warm-up: programmable current and seconds, zero skips.
// (RULE15) Laser On reported while armed, modulation aside.
// (RULE16) Clearing a fault moves Fault to Aborted.
// (RULE17) Run mode is one-hot, four modes.
// (RULE18) Power setpoint limited to nominal power.
// (RULE19) Current setpoint limited to maximum current.
// (RULE20) Run mode resets to constant power.
// (RULE21) Autostart resets to enabled.
// (RULE22) Autostart disabled may skip temperature wait.
// (RULE23) Remote ON low stops emission, waits remote.
// (RULE24) Interlock open stops laser, key toggle restarts.
// (RULE25) Interlock filtered within the reaction limit.
// (RULE26) Any detected fault inhibits emission, enters Fault.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module lss_seq #(
  parameter int unsigned SEC_CYC = 40000000,
  parameter int unsigned ILOCK_CYC = 400000,
  parameter logic [lss_pkg::VAL_W-1:0] NOM_PWR = 16'h012C,
  parameter logic [lss_pkg::VAL_W-1:0] MAX_CUR = 16'h01B8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_on,
  input wire logic remote_on,
  input wire logic ilock_closed,
  input wire logic temp_settled,
  input wire logic fault_det,
  output lss_pkg::lss_state_t state,
  output logic emission_en,
  output logic tec_en,
  output logic warm_drive_en,
  output logic [lss_pkg::VAL_W-1:0] warm_cur,
  output logic [3:0] run_mode,
  output logic [lss_pkg::VAL_W-1:0] pwr_set,
  output logic [lss_pkg::VAL_W-1:0] cur_set
);
  import lss_pkg::*;

  localparam int SC_W = $clog2(SEC_CYC + 1);

  // ==========================================================================
  // Declarations.
  logic key_lvl;
  logic remote_lvl;
  logic ilock_lvl;
  logic temp_lvl;
  logic fault_lvl;
  logic auto_en;
  logic remote_en;
  logic [SECS_W-1:0] warm_secs;
  logic next_auto_en;
  logic next_remote_en;
  logic [3:0] next_run_mode;
  logic [VAL_W-1:0] next_pwr_set;
  logic [VAL_W-1:0] next_cur_set;
  logic [VAL_W-1:0] next_warm_cur;
  logic [SECS_W-1:0] next_warm_secs;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wr_acc;
  logic [4:0] cmd;
  lss_state_t next_state;
  logic boot;
  logic next_boot;
  logic key_off_seen;
  logic next_key_off_seen;
  logic [SC_W-1:0] sub_cnt;
  logic [SC_W-1:0] next_sub_cnt;
  logic [SECS_W-1:0] sec_cnt;
  logic [SECS_W-1:0] next_sec_cnt;
  logic running;

  // ==========================================================================
  // Input conditioning. The interlock filter stays well inside the
  // reaction limit; other pins only need their synchronisers.
  lss_filter #(.FILT_CYC(ILOCK_CYC), .RST_VAL(1'b0)) u_ilock ( // RULE25
    .mclk(mclk),
    .rst(rst),
    .pin(ilock_closed),
    .level(ilock_lvl)
  );
  // The key resets as on, so the reset value never counts as a turn-off.
  lss_filter #(.FILT_CYC(1), .RST_VAL(1'b1)) u_key (
    .mclk(mclk),
    .rst(rst),
    .pin(key_on),
    .level(key_lvl)
  );
  lss_filter #(.FILT_CYC(1), .RST_VAL(1'b0)) u_remote (
    .mclk(mclk),
    .rst(rst),
    .pin(remote_on),
    .level(remote_lvl)
  );
  lss_filter #(.FILT_CYC(1), .RST_VAL(1'b0)) u_temp (
    .mclk(mclk),
    .rst(rst),
    .pin(temp_settled),
    .level(temp_lvl)
  );
  lss_filter #(.FILT_CYC(1), .RST_VAL(1'b0)) u_fault (
    .mclk(mclk),
    .rst(rst),
    .pin(fault_det),
    .level(fault_lvl)
  );

  // ==========================================================================
  // APB slave. Zero wait states: writes land at the access edge and read
  // data is prepared during the setup cycle so it leaves a flop.
  assign wr_acc = psel & penable & pwrite;
  assign cmd = (wr_acc && paddr == ADDR_CMD) ? pwdata[4:0] : 5'h00;

  always_comb begin
    next_auto_en = auto_en;
    next_remote_en = remote_en;
    next_run_mode = run_mode;
    next_pwr_set = pwr_set;
    next_cur_set = cur_set;
    next_warm_cur = warm_cur;
    next_warm_secs = warm_secs;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_CMD: begin
          next_prdata = 32'h0000_0000;
        end
        ADDR_CFG: begin
          next_prdata[CFG_AUTO] = auto_en;
          next_prdata[CFG_REMOTE] = remote_en;
          next_prdata[CFG_MODE_MSB:CFG_MODE_LSB] = run_mode;
          if (pwrite && !$onehot(pwdata[CFG_MODE_MSB:CFG_MODE_LSB])) begin
            next_pslverr = 1'b1; // RULE17
          end
        end
        ADDR_STATUS: begin
          next_prdata[STS_STATE_MSB:STS_STATE_LSB] = state;
          next_prdata[STS_ILOCK] = ilock_lvl;
          next_prdata[STS_KEY] = key_lvl;
          next_prdata[STS_REMOTE] = remote_lvl;
          next_prdata[STS_TEMP_OK] = temp_lvl;
        end
        ADDR_PWR_SET: begin
          next_prdata[VAL_W-1:0] = pwr_set;
          if (pwrite && (pwdata[31:VAL_W] != '0 ||
              pwdata[VAL_W-1:0] > NOM_PWR)) begin
            next_pslverr = 1'b1; // RULE18
          end
        end
        ADDR_CUR_SET: begin
          next_prdata[VAL_W-1:0] = cur_set;
          if (pwrite && (pwdata[31:VAL_W] != '0 ||
              pwdata[VAL_W-1:0] > MAX_CUR)) begin
            next_pslverr = 1'b1; // RULE19
          end
        end
        ADDR_WARM_CUR: begin
          next_prdata[VAL_W-1:0] = warm_cur;
        end
        ADDR_WARM_TIME: begin
          next_prdata[SECS_W-1:0] = warm_secs;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      next_pslverr = pslverr;
    end
    // A write flagged in setup is refused and leaves the register as is.
    if (wr_acc && !pslverr) begin
      unique case (paddr)
        ADDR_CFG: begin
          next_auto_en = pwdata[CFG_AUTO];
          next_remote_en = pwdata[CFG_REMOTE];
          next_run_mode = pwdata[CFG_MODE_MSB:CFG_MODE_LSB]; // RULE17
        end
        ADDR_PWR_SET: next_pwr_set = pwdata[VAL_W-1:0]; // RULE18
        ADDR_CUR_SET: next_cur_set = pwdata[VAL_W-1:0]; // RULE19
        ADDR_WARM_CUR: next_warm_cur = pwdata[VAL_W-1:0]; // RULE14
        ADDR_WARM_TIME: next_warm_secs = pwdata[SECS_W-1:0]; // RULE14
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      auto_en <= CFG_AUTO_RST; // RULE21
      remote_en <= CFG_REMOTE_RST;
      run_mode <= MODE_CONST_PWR; // RULE20
      pwr_set <= VAL_ZERO;
      cur_set <= VAL_ZERO;
      warm_cur <= VAL_ZERO; // RULE14
      warm_secs <= SECS_ZERO; // RULE14
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      auto_en <= next_auto_en;
      remote_en <= next_remote_en;
      run_mode <= next_run_mode;
      pwr_set <= next_pwr_set;
      cur_set <= next_cur_set;
      warm_cur <= next_warm_cur;
      warm_secs <= next_warm_secs;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= 1'b1;
    end
  end

  // ==========================================================================
  // Sequencer. Priority: fault, abort, stop, interlock, remote, then the
  // normal forward steps of the startup sequence.
  assign running = (state == ST_WAIT_REMOTE) || (state == ST_WAIT_TEMP) ||
                   (state == ST_WARMUP) || (state == ST_LASER_ON);

  always_comb begin
    next_state = state;
    next_boot = 1'b0;
    next_key_off_seen = key_off_seen | ~key_lvl;
    next_sub_cnt = '0;
    next_sec_cnt = '0;
    if (fault_lvl && state != ST_FAULT) begin
      next_state = ST_FAULT; // RULE26 RULE3
    end else if (state == ST_FAULT) begin
      // A clear while the fault is still present is ignored.
      if (cmd[CMD_CLR_FAULT] && !fault_lvl) begin // RULE3
        next_state = ST_ABORTED; // RULE16 RULE1
      end
    end else if (cmd[CMD_ABORT]) begin
      next_state = ST_ABORTED; // RULE1
    end else if (state == ST_ABORTED) begin
      if (cmd[CMD_RESTART]) begin
        next_state = ST_WAIT_KEY; // RULE4
        next_key_off_seen = 1'b0;
      end
    end else if (cmd[CMD_STOP]) begin
      next_state = ST_STANDBY; // RULE6
    end else if (running && !ilock_lvl) begin
      next_state = ST_WAIT_KEY; // RULE24
      next_key_off_seen = 1'b0;
    end else if (remote_en && !remote_lvl &&
                 state != ST_STANDBY && state != ST_WAIT_KEY &&
                 state != ST_WAIT_REMOTE) begin
      next_state = ST_WAIT_REMOTE; // RULE23
    end else begin
      unique case (state)
        ST_STANDBY: begin
          // After reset the sequence leaves Standby on its own only when
          // autostart is on; otherwise the host must start it.
          if (cmd[CMD_START] || cmd[CMD_RESTART] || (boot && auto_en)) begin
            next_state = ST_WAIT_KEY; // RULE8 RULE5
            next_key_off_seen = 1'b0;
          end
        end
        ST_WAIT_KEY: begin
          // A key already on does not count; the off level must be seen.
          if (key_off_seen && key_lvl && ilock_lvl) begin // RULE9 RULE10
            next_state = remote_en ? ST_WAIT_REMOTE : ST_WAIT_TEMP; // RULE11
          end
        end
        ST_WAIT_REMOTE: begin
          if (!remote_en || remote_lvl) begin
            next_state = ST_WAIT_TEMP; // RULE11
          end
        end
        ST_WAIT_TEMP: begin
          if (temp_lvl || !auto_en) begin // RULE12 RULE22
            next_state = ST_WARMUP; // RULE13
          end
        end
        ST_WARMUP: begin
          next_sub_cnt = sub_cnt;
          next_sec_cnt = sec_cnt;
          if (sec_cnt >= warm_secs) begin
            next_state = ST_LASER_ON; // RULE13 RULE14
          end else if (sub_cnt >= SC_W'(SEC_CYC - 1)) begin
            next_sub_cnt = '0;
            next_sec_cnt = sec_cnt + SECS_W'(1);
          end else begin
            next_sub_cnt = sub_cnt + SC_W'(1);
          end
        end
        ST_LASER_ON: begin
          next_state = ST_LASER_ON; // RULE15
        end
        ST_FAULT: begin
          next_state = ST_FAULT;
        end
        ST_ABORTED: begin
          next_state = ST_ABORTED;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_STANDBY; // RULE5
      boot <= 1'b1;
      key_off_seen <= 1'b0;
      sub_cnt <= '0;
      sec_cnt <= '0;
    end else begin
      state <= next_state;
      boot <= next_boot;
      key_off_seen <= next_key_off_seen;
      sub_cnt <= next_sub_cnt;
      sec_cnt <= next_sec_cnt;
    end
  end

  // ==========================================================================
  // Drive outputs, registered from the next state so they change together
  // with the state. Emission is armed only in Laser On, whatever the
  // run mode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      emission_en <= 1'b0;
      tec_en <= 1'b1;
      warm_drive_en <= 1'b0;
    end else begin
      emission_en <= (next_state == ST_LASER_ON); // RULE15 RULE26 RULE2
      tec_en <= (next_state != ST_ABORTED); // RULE2 RULE7
      warm_drive_en <= (next_state == ST_WARMUP) &&
                       (warm_secs != SECS_ZERO); // RULE14
    end
  end

endmodule : lss_seq

// ---- test/lss_tplant.sv ----
// Temperature plant model standing behind the sequencer's drive outputs.
`timescale 1ns/100ps
module lss_tplant (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tec_en,
  input wire logic [7:0] settle,
  output logic temp_settled
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // ==========================================================================
  // Settling timer
  // Losing the drives loses the setpoint, so the count restarts from zero.
  always_comb begin
    next_cnt = cnt;
    if (!tec_en) begin
      next_cnt = 8'h00;
    end else if (cnt != 8'hFF) begin
      next_cnt = cnt + 8'h01;
    end
  end

  // Register the timer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  // A large settle value makes the plant slow, a small one prompt.
  assign temp_settled = (cnt >= settle);
endmodule : lss_tplant

// ---- test/lss_seq_asserts.sv ----
// Concurrent checks on the ports of the startup sequencer.
`timescale 1ns/100ps
module lss_seq_asserts #(
  parameter logic [lss_pkg::VAL_W-1:0] NOM_PWR = 16'h012C,
  parameter logic [lss_pkg::VAL_W-1:0] MAX_CUR = 16'h01B8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire lss_pkg::lss_state_t state,
  input wire logic emission_en,
  input wire logic tec_en,
  input wire logic warm_drive_en,
  input wire logic [3:0] run_mode,
  input wire logic [lss_pkg::VAL_W-1:0] pwr_set,
  input wire logic [lss_pkg::VAL_W-1:0] cur_set
);
  import lss_pkg::*;
  logic cmd;

  // ==========================================================================
  // A committed write to the command register.
  assign cmd = psel && penable && pwrite && pready && (paddr == ADDR_CMD);

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_emit_state: assert property (
    emission_en == (state == ST_LASER_ON))
    else $error("Emission out of step with state.");
  a_drive_abort: assert property (
    tec_en == (state != ST_ABORTED))
    else $error("Temperature drives wrong for state.");
  a_mode_onehot: assert property ($onehot(run_mode))
    else $error("Run mode not one-hot.");
  a_pwr_limit: assert property (pwr_set <= NOM_PWR)
    else $error("Power setpoint above nominal.");
  a_cur_limit: assert property (cur_set <= MAX_CUR)
    else $error("Current setpoint above maximum.");
  a_warm_only: assert property (warm_drive_en |-> state == ST_WARMUP)
    else $error("Warm-up drive outside warm-up.");
  a_fault_hold: assert property (
    state == ST_FAULT && !(cmd && pwdata[CMD_CLR_FAULT]) |=> state == ST_FAULT)
    else $error("Fault left without a clear.");
  a_abort_hold: assert property (
    state == ST_ABORTED && !(cmd && pwdata[CMD_RESTART])
    |=> state inside {ST_ABORTED, ST_FAULT})
    else $error("Aborted left without a restart.");
  a_abort_cmd: assert property (
    cmd && pwdata[CMD_ABORT] && !(state inside {ST_FAULT, ST_ABORTED})
    |=> state inside {ST_ABORTED, ST_FAULT})
    else $error("Abort command not obeyed.");
  a_stop_cmd: assert property (
    cmd && pwdata[CMD_STOP] && !pwdata[CMD_ABORT]
    && !(state inside {ST_FAULT, ST_ABORTED})
    |=> state inside {ST_STANDBY, ST_FAULT})
    else $error("Stop command not obeyed.");

  c_laser_on: cover property (state == ST_LASER_ON);
  c_aborted: cover property (state == ST_ABORTED);
  c_warm: cover property (warm_drive_en);
  c_remote: cover property (state == ST_WAIT_REMOTE);
endmodule : lss_seq_asserts

bind lss_seq lss_seq_asserts #(.NOM_PWR(NOM_PWR), .MAX_CUR(MAX_CUR)) i_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .state(state),
  .emission_en(emission_en), .tec_en(tec_en), .warm_drive_en(warm_drive_en),
  .run_mode(run_mode), .pwr_set(pwr_set), .cur_set(cur_set));

// ---- test/laser_startup_state_sequencer_test.sv ----
// Self-checking bench for the laser startup state sequencer.
`timescale 1ns/100ps
module laser_startup_state_sequencer_test;
  import lss_pkg::*;
  localparam int unsigned SEC = 10;
  localparam logic [31:0] NOM = 32'h0000012C;
  localparam logic [31:0] MAXC = 32'h000001B8;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [7:0] settle;
  logic [31:0] pwdata, prdata;
  logic key_on, remote_on, ilock_closed, fault_det, temp_settled;
  logic emission_en, tec_en, warm_drive_en;
  logic [3:0] run_mode;
  logic [VAL_W-1:0] warm_cur, pwr_set, cur_set;
  lss_state_t state;
  int err_total = 0, samples_checked = 0, cyc = 0, warm_cyc = 0, n, w0;

  lss_seq #(.SEC_CYC(SEC), .ILOCK_CYC(4)) i_dut (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_on(key_on), .remote_on(remote_on), .ilock_closed(ilock_closed),
    .temp_settled(temp_settled), .fault_det(fault_det), .state(state),
    .emission_en(emission_en), .tec_en(tec_en),
    .warm_drive_en(warm_drive_en), .warm_cur(warm_cur),
    .run_mode(run_mode), .pwr_set(pwr_set), .cur_set(cur_set));
  lss_tplant i_plant (.mclk(mclk), .rst(rst), .tec_en(tec_en),
    .settle(settle), .temp_settled(temp_settled));

  // ==========================================================================
  // Clock, hang guard and warm-up cycle counter.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  always @(posedge mclk) if (state === ST_WARMUP) warm_cyc <= warm_cyc + 1;

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; waits for pready, then takes data at that edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Wait for the answer; if pready never comes, only the hang guard ends this wait.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    if (!w) chk("prdata", prdata, exp);
    chk("pslverr", 32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_st(input lss_state_t s);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (state !== s && n < 400);
    chk("state", 32'(state), 32'(s));
  endtask : wait_st

  // The key must be seen off and then on again.
  task automatic tog();
    @(posedge mclk);
    key_on <= 1'b0;
    repeat (6) @(posedge mclk);
    key_on <= 1'b1;
  endtask : tog

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Main sequence.
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst = 1;
    key_on = 1; remote_on = 0; ilock_closed = 1; fault_det = 0;
    settle = 8'd120;
    repeat (4) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_STANDBY));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    apb(0, ADDR_CFG, 0, 32'h11, 0);
    apb(0, 8'h1C, 0, 0, 1);
    repeat (20) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_WAIT_KEY));
    tog();
    wait_st(ST_WAIT_TEMP);
    w0 = warm_cyc;
    wait_st(ST_LASER_ON);
    chk("warm", 32'(warm_cyc - w0), 1);
    chk("emission_en", 32'(emission_en), 1);
    apb(0, ADDR_STATUS, 0, 32'hB5, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CFG, {24'h0, 4'(1 << i), 4'h1}, 0, 0);
      apb(0, ADDR_CFG, 0, {24'h0, 4'(1 << i), 4'h1}, 0);
    end
    apb(1, ADDR_CFG, 32'h31, 0, 1);
    apb(0, ADDR_CFG, 0, 32'h81, 0);
    apb(1, ADDR_CFG, 32'h11, 0, 0);
    apb(1, ADDR_PWR_SET, NOM, 0, 0);
    apb(1, ADDR_PWR_SET, NOM + 1, 0, 1);
    apb(0, ADDR_PWR_SET, 0, NOM, 0);
    apb(1, ADDR_CUR_SET, MAXC + 1, 0, 1);
    apb(0, ADDR_CUR_SET, 0, 0, 0);
    apb(1, ADDR_WARM_CUR, 32'h50, 0, 0);
    #1 chk("warm_cur", 32'(warm_cur), 32'h50);
    apb(1, ADDR_CMD, 32'h1, 0, 0);
    #1 chk("state", 32'(state), 32'(ST_STANDBY));
    chk("emission_en", 32'(emission_en), 0);
    chk("tec_en", 32'(tec_en), 1);
    apb(1, ADDR_CMD, 32'h2, 0, 0);
    wait_st(ST_WAIT_KEY);
    apb(1, ADDR_CMD, 32'h8, 0, 0);
    #1 chk("state", 32'(state), 32'(ST_ABORTED));
    chk("tec_en", 32'(tec_en), 0);
    apb(1, ADDR_CMD, 32'h2, 0, 0);
    repeat (20) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_ABORTED));
    apb(1, ADDR_CMD, 32'h4, 0, 0);
    #1 chk("state", 32'(state), 32'(ST_WAIT_KEY));
    @(posedge mclk);
    fault_det <= 1'b1;
    wait_st(ST_FAULT);
    apb(1, ADDR_CMD, 32'h10, 0, 0);
    #1 chk("state", 32'(state), 32'(ST_FAULT));
    repeat (5) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_FAULT));
    fault_det <= 1'b0;
    repeat (5) @(posedge mclk);
    apb(1, ADDR_CMD, 32'h10, 0, 0);
    #1 chk("state", 32'(state), 32'(ST_ABORTED));
    settle <= 8'd3;
    apb(1, ADDR_CMD, 32'h4, 0, 0);
    apb(1, ADDR_CFG, 32'h13, 0, 0);
    tog();
    wait_st(ST_WAIT_REMOTE);
    repeat (20) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_WAIT_REMOTE));
    remote_on <= 1'b1;
    wait_st(ST_LASER_ON);
    remote_on <= 1'b0;
    wait_st(ST_WAIT_REMOTE);
    remote_on <= 1'b1;
    wait_st(ST_LASER_ON);
    // A short interlock glitch must be swallowed by the filter.
    ilock_closed <= 1'b0;
    repeat (2) @(posedge mclk);
    ilock_closed <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("state", 32'(state), 32'(ST_LASER_ON));
    ilock_closed <= 1'b0;
    wait_st(ST_WAIT_KEY);
    ilock_closed <= 1'b1;
    repeat (12) @(posedge mclk);
    apb(1, ADDR_CFG, 32'h11, 0, 0);
    apb(1, ADDR_WARM_TIME, 32'h2, 0, 0);
    w0 = warm_cyc;
    // An operator may toggle twice; the second toggle must do no harm.
    tog();
    tog();
    wait_st(ST_WARMUP);
    chk("warm_drive_en", 32'(warm_drive_en), 1);
    wait_st(ST_LASER_ON);
    chk("warm", 32'(warm_cyc - w0), 2 * SEC + 1);
    settle <= 8'd120;
    apb(1, ADDR_CMD, 32'h8, 0, 0);
    apb(1, ADDR_CMD, 32'h4, 0, 0);
    apb(1, ADDR_CFG, 32'h10, 0, 0);
    tog();
    wait_st(ST_WARMUP);
    chk("temp_settled", 32'(temp_settled), 0);
    print_verdict();
  end
endmodule : laser_startup_state_sequencer_test
